// *** design/ats_fifo.sv ***
// Parameterised sample FIFO with valid and ready on both sides
`timescale 1ns/1ps
module ats_fifo #(
    parameter int W = 32, // Word width
    parameter int DEPTH = 16 // Number of words
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic s_valid, // Fill side word offered
    input wire logic [W-1:0] s_data, // Fill side word
    output logic s_ready, // Room for a word
    output logic m_valid, // Drain side word present
    output logic [W-1:0] m_data, // Head word
    input wire logic m_ready // Drain side takes the head
);
    localparam int AW = $clog2(DEPTH); // Pointer width
    localparam int CW = $clog2(DEPTH + 1); // Count width

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem; // Storage
        logic [AW-1:0] wp; // Write pointer
        logic [AW-1:0] rp; // Read pointer
        logic [CW-1:0] cnt; // Words held
        logic rdy; // Room for a word, kept in a flop so the ready output is registered
    } ats_fifo_state_t;

    ats_fifo_state_t st_r; // Registered state
    ats_fifo_state_t st_nxt; // Next state
    logic push; // Word accepted
    logic pop; // Word removed

    assign s_ready = st_r.rdy;
    assign m_valid = (st_r.cnt != '0);
    assign m_data = st_r.mem[st_r.rp];
    assign push = s_valid && s_ready;
    assign pop = m_valid && m_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Pointer and count update; a full FIFO refuses, so the source stalls
    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wp] = s_data;
            st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : AW'(st_r.wp + 1'b1);
        end
        if (pop)
        begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : AW'(st_r.rp + 1'b1);
        end
        st_nxt.cnt = CW'(st_r.cnt + CW'(push) - CW'(pop));
        // Ready follows the next count, so it drops at the same clock edge that fills the last slot
        st_nxt.rdy = (st_nxt.cnt != CW'(DEPTH));
    end

    // State register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
            st_r.rdy <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // Count never passes the depth
    fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_b) st_r.cnt <= CW'(DEPTH))
        else $error("fifo count above depth");
endmodule : ats_fifo

// *** design/ats_pkg.sv ***
// Constants, register map and types for the transmit slot mapper
package ats_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] ADDR_FORMAT = 8'h1A; // Protocol and slot length
    localparam logic [7:0] ADDR_FILL = 8'h1B; // Unused cycle fill
    localparam logic [7:0] ADDR_OFFSET = 8'h1C; // tx_slot0_offset
    localparam logic [7:0] ADDR_PINSEL = 8'h1D; // tx_channel_pin_select
    localparam logic [7:0] ADDR_CH1 = 8'h1E; // tx_channel1_config

    // Reset values
    localparam logic [7:0] RST_FORMAT = 8'h30; // TDM, 32-bit slots
    localparam logic [7:0] RST_FILL = 8'h00; // Drive zero when unused
    localparam logic [7:0] RST_OFFSET = 8'h00; // No slot 0 delay
    localparam logic [7:0] RST_PINSEL = 8'h00; // All channels on primary pin
    localparam logic [7:0] RST_CH1 = 8'h20; // Enabled, slot 0

    // Writable bit masks; all other bits are reserved and read zero
    localparam logic [7:0] MASK_FORMAT = 8'hF0; // Format and length only
    localparam logic [7:0] MASK_FILL = 8'h40; // Fill bit only
    localparam logic [7:0] MASK_OFFSET = 8'h1F; // Offset field
    localparam logic [7:0] MASK_PINSEL = 8'hFF; // Eight pin choices
    localparam logic [7:0] MASK_CH1 = 8'h3F; // Enable and slot index

    // Field positions
    localparam int PROTO_LSB = 6; // protocol_select[1:0]
    localparam int LEN_LSB = 4; // slot_length_select[1:0]
    localparam int FILL_BIT = 6; // unused_cycle_fill
    localparam int OFFSET_LSB = 0; // slot0_msb_delay[4:0]
    localparam int CH1_EN_BIT = 5; // chan1_output_enable
    localparam int CH1_SLOT_LSB = 0; // chan1_slot_index[4:0]

    // Frame geometry
    localparam logic [5:0] SLOT_LIMIT = 6'h20; // Slot counter parks here past slot 31
    localparam int SAMPLE_W = 32; // Channel sample width, MSB aligned
    localparam int FIFO_DEPTH = 16; // Sample buffer depth

    // Protocol selection
    typedef enum logic [1:0] {
        PROTO_TDM = 2'b00,
        PROTO_I2S = 2'b01,
        PROTO_LJ = 2'b10,
        PROTO_RSVD = 2'b11
    } ats_proto_t;

    // Slot length in bit clocks for a length code
    function automatic logic [5:0] slot_bits(input logic [1:0] code);
        unique case (code)
            2'h0: slot_bits = 6'h10;
            2'h1: slot_bits = 6'h14;
            2'h2: slot_bits = 6'h18;
            2'h3: slot_bits = 6'h20;
        endcase
    endfunction : slot_bits

endpackage : ats_pkg

// *** design/ats_slot_mapper.sv ***
// Transmit slot mapper of the primary audio port: registers, framing and pin drive
// Overview of operation
// - Delay slot 0 MSB by offset bit clocks
// - Zero offset keeps standard MSB position
// - Pin choice bit routes channel to pin
// - Disabled channel 1 slot stays tri-stated
// - Slot index picks TDM or half slot
// - Format selects TDM, I2S or left-justified
// - Length code sets 16/20/24/32-bit slots
// - Unused cycles drive zero or float
`timescale 1ns/1ps
module ats_slot_mapper (
    input wire logic MCLK, // 20 MHz system clock
    input wire logic RST_B, // Asynchronous reset, active low
    input wire logic [7:0] REG_ADDR, // Register address
    input wire logic [7:0] REG_WDATA, // Register write data
    input wire logic REG_WE, // Write strobe, one cycle
    output logic [7:0] REG_RDATA, // Read data, one cycle after address
    input wire logic BCLK, // Bit clock pin from host
    input wire logic FSYNC, // Frame sync pin from host
    input wire logic S_VALID, // Channel 1 sample offered
    input wire logic [31:0] S_DATA, // Channel 1 sample, MSB aligned
    output logic S_READY, // Sample buffer has room
    output logic DOUT, // Primary serial out data
    output logic DOUT_OE_B, // Primary out enable, low drives
    output logic SECONDARY_SERIAL_OUT, // Secondary serial out data
    output logic SECONDARY_SERIAL_OUT_OE_B // Secondary out enable, low drives
);

    typedef struct packed {
        logic [1:0] proto_r; // protocol_select
        logic [1:0] len_r; // slot_length_select
        logic fill_r; // unused_cycle_fill
        logic [4:0] delay_cfg_r; // slot0_msb_delay
        logic [7:0] pinsel_r; // chan1..chan8 pin choice
        logic ch1_en_r; // chan1_output_enable
        logic [4:0] ch1_slot_r; // chan1_slot_index
        logic [7:0] rdata_r; // Read data
        logic [2:0] bclk_r; // Bit clock sync chain and edge history
        logic [1:0] fsync_r; // Frame sync sync chain
        logic fs_prev_r; // Frame sync at previous rising edge
        logic framed_r; // A frame start has been seen
        logic right_r; // Current half is the right one
        logic [5:0] delay_r; // Padding bits left before slot 0
        logic [5:0] bit_r; // Bit within slot
        logic [5:0] slot_r; // Slot within frame or half
        logic [31:0] shift_r; // Outgoing sample
        logic hit_r; // Current bit lies in channel 1 slot
        logic active_r; // Channel 1 slot and enabled
        logic dout_r; // Primary data
        logic dout_oe_b_r; // Primary enable
        logic secondary_serial_out_r; // Secondary data
        logic secondary_serial_out_oe_b_r; // Secondary enable
    } ats_state_t;

    ats_state_t st_r; // Registered state
    ats_state_t st_nxt; // Next state
    logic rise_ev; // Bit clock rising edge seen
    logic fall_ev; // Bit clock falling edge seen
    logic fs; // Synchronised frame sync
    logic fs_rise; // Frame sync went high
    logic fs_fall; // Frame sync went low
    logic start_l; // Left half or TDM frame begins
    logic start_r; // Right half begins
    logic is_tdm; // TDM framing
    logic is_i2s; // I2S framing
    logic [5:0] len; // Slot length in bits
    logic fifo_valid; // Sample waiting
    logic [31:0] fifo_data; // Head sample
    logic fifo_pop; // Take head sample

    ////////////////////////////////////////////////////////////////////////////
    // Register read decode; unmapped addresses read zero
    function automatic logic [7:0] reg_read(input ats_state_t s, input logic [7:0] a);
        unique case (a)
            ats_pkg::ADDR_FORMAT: reg_read = {s.proto_r, s.len_r, 4'h0};
            ats_pkg::ADDR_FILL: reg_read = {1'b0, s.fill_r, 6'h00};
            ats_pkg::ADDR_OFFSET: reg_read = {3'h0, s.delay_cfg_r};
            ats_pkg::ADDR_PINSEL: reg_read = s.pinsel_r;
            ats_pkg::ADDR_CH1: reg_read = {2'h0, s.ch1_en_r, s.ch1_slot_r};
            default: reg_read = 8'h00;
        endcase
    endfunction : reg_read

    // Drive of one pin for the coming bit: {data, enable_b}
    function automatic logic [1:0] pin_drive(input ats_state_t s, input logic pin);
        if (s.hit_r && (s.pinsel_r[0] == pin))
            pin_drive = s.active_r ? {s.shift_r[31], 1'b0} : 2'b01;
        else
            pin_drive = s.fill_r ? 2'b01 : 2'b00;
    endfunction : pin_drive

    ////////////////////////////////////////////////////////////////////////////
    // Edge and framing decode from synchronised pins
    assign rise_ev = st_r.bclk_r[1] && !st_r.bclk_r[2];
    assign fall_ev = !st_r.bclk_r[1] && st_r.bclk_r[2];
    assign fs = st_r.fsync_r[1];
    assign fs_rise = fs && !st_r.fs_prev_r;
    assign fs_fall = !fs && st_r.fs_prev_r;
    assign is_tdm = (st_r.proto_r == ats_pkg::PROTO_TDM);
    assign is_i2s = (st_r.proto_r == ats_pkg::PROTO_I2S);
    // I2S opens the left half on the falling sync, LJ and TDM on the rising one
    assign start_l = is_i2s ? fs_fall : fs_rise;
    assign start_r = !is_tdm && (is_i2s ? fs_rise : fs_fall);
    assign len = ats_pkg::slot_bits(st_r.len_r);

    ////////////////////////////////////////////////////////////////////////////
    // Sample buffer in front of the shifter
    ats_fifo #(
        .W(ats_pkg::SAMPLE_W),
        .DEPTH(ats_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_b(RST_B),
        .s_valid(S_VALID),
        .s_data(S_DATA),
        .s_ready(S_READY),
        .m_valid(fifo_valid),
        .m_data(fifo_data),
        .m_ready(fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state: registers, counters on rising bit clock, pins on falling
    always_comb
    begin
        logic win; // Next bit position is channel 1's slot
        logic [1:0] p0; // Primary pin drive
        logic [1:0] p1; // Secondary pin drive
        win = 1'b0;
        p0 = 2'b00;
        p1 = 2'b00;
        st_nxt = st_r;
        fifo_pop = 1'b0;
        // Pin synchronisers; stage 0 only feeds stage 1
        st_nxt.bclk_r = {st_r.bclk_r[1:0], BCLK};
        st_nxt.fsync_r = {st_r.fsync_r[0], FSYNC};
        st_nxt.rdata_r = reg_read(st_r, REG_ADDR);
        // Reserved bits are masked, so stray ones never stick
        if (REG_WE)
        begin
            unique case (REG_ADDR)
                ats_pkg::ADDR_FORMAT:
                begin
                    st_nxt.proto_r = REG_WDATA[ats_pkg::PROTO_LSB +: 2];
                    st_nxt.len_r = REG_WDATA[ats_pkg::LEN_LSB +: 2];
                end
                ats_pkg::ADDR_FILL: st_nxt.fill_r = REG_WDATA[ats_pkg::FILL_BIT];
                ats_pkg::ADDR_OFFSET: st_nxt.delay_cfg_r = REG_WDATA[ats_pkg::OFFSET_LSB +: 5];
                ats_pkg::ADDR_PINSEL: st_nxt.pinsel_r = REG_WDATA & ats_pkg::MASK_PINSEL;
                ats_pkg::ADDR_CH1:
                begin
                    st_nxt.ch1_en_r = REG_WDATA[ats_pkg::CH1_EN_BIT];
                    st_nxt.ch1_slot_r = REG_WDATA[ats_pkg::CH1_SLOT_LSB +: 5];
                end
                default: st_nxt.rdata_r = st_nxt.rdata_r;
            endcase
        end
        // Bit position advances on each rising bit clock once framed and past the slot 0 delay
        if (rise_ev)
        begin
            st_nxt.fs_prev_r = fs;
            if (st_r.proto_r == ats_pkg::PROTO_RSVD)
            begin
                st_nxt.framed_r = 1'b0;
            end
            else if (start_l || start_r)
            begin
                st_nxt.framed_r = 1'b1;
                st_nxt.right_r = start_r;
                // I2S puts the MSB one bit late, the offset adds more
                st_nxt.delay_r = 6'({1'b0, st_r.delay_cfg_r} + {5'h00, is_i2s});
                st_nxt.bit_r = 6'h00;
                st_nxt.slot_r = 6'h00;
            end
            else if (st_r.framed_r)
            begin
                if (st_r.delay_r != 6'h00)
                    st_nxt.delay_r = 6'(st_r.delay_r - 6'h01);
                else if (st_r.bit_r == 6'(len - 6'h01))
                begin
                    st_nxt.bit_r = 6'h00;
                    if (st_r.slot_r != ats_pkg::SLOT_LIMIT)
                        st_nxt.slot_r = 6'(st_r.slot_r + 6'h01);
                end
                else
                    st_nxt.bit_r = 6'(st_r.bit_r + 6'h01);
            end
            // Channel 1 slot match; halves hold 16 slots outside TDM
            if (is_tdm)
                win = (st_nxt.slot_r == {1'b0, st_r.ch1_slot_r});
            else
                win = (st_nxt.slot_r == {2'h0, st_r.ch1_slot_r[3:0]}) &&
                      (st_nxt.right_r == st_r.ch1_slot_r[4]);
            win = win && st_nxt.framed_r && (st_nxt.delay_r == 6'h00);
            st_nxt.hit_r = win;
            st_nxt.active_r = win && st_r.ch1_en_r;
            // Load at slot start; an empty buffer sends silence
            if (st_nxt.active_r && (st_nxt.bit_r == 6'h00))
            begin
                fifo_pop = fifo_valid;
                st_nxt.shift_r = fifo_valid ? fifo_data : 32'h0000_0000;
            end
            else if (st_r.active_r)
                st_nxt.shift_r = {st_r.shift_r[30:0], 1'b0};
        end
        // Pins change on the falling bit clock so the host samples on rising
        if (fall_ev)
        begin
            p0 = pin_drive(st_r, 1'b0);
            p1 = pin_drive(st_r, 1'b1);
            {st_nxt.dout_r, st_nxt.dout_oe_b_r} = p0;
            {st_nxt.secondary_serial_out_r, st_nxt.secondary_serial_out_oe_b_r} = p1;
        end
    end

    // State register; pins released during reset
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_r <= '0;
            {st_r.proto_r, st_r.len_r} <= ats_pkg::RST_FORMAT[7:4];
            st_r.fill_r <= ats_pkg::RST_FILL[ats_pkg::FILL_BIT];
            st_r.delay_cfg_r <= ats_pkg::RST_OFFSET[4:0];
            st_r.pinsel_r <= ats_pkg::RST_PINSEL;
            {st_r.ch1_en_r, st_r.ch1_slot_r} <= ats_pkg::RST_CH1[5:0];
            st_r.dout_oe_b_r <= 1'b1;
            st_r.secondary_serial_out_oe_b_r <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign REG_RDATA = st_r.rdata_r;
    assign DOUT = st_r.dout_r;
    assign DOUT_OE_B = st_r.dout_oe_b_r;
    assign SECONDARY_SERIAL_OUT = st_r.secondary_serial_out_r;
    assign SECONDARY_SERIAL_OUT_OE_B = st_r.secondary_serial_out_oe_b_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    offset_load_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (rise_ev && start_l && st_r.proto_r == ats_pkg::PROTO_LJ) |=> st_r.delay_r == {1'b0, $past(st_r.delay_cfg_r)})
        else $error("slot 0 delay not loaded from offset");
    zero_offset_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (rise_ev && start_l && is_tdm && st_r.delay_cfg_r == 5'h00) |=> st_r.delay_r == 6'h00 && st_r.bit_r == 6'h00)
        else $error("zero offset added delay");
    primary_route_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (fall_ev && st_r.active_r && !st_r.pinsel_r[0]) |=> !DOUT_OE_B && DOUT == $past(st_r.shift_r[31]))
        else $error("channel 1 missing on primary pin");
    secondary_route_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (fall_ev && st_r.active_r && st_r.pinsel_r[0]) |=> !SECONDARY_SERIAL_OUT_OE_B &&
        SECONDARY_SERIAL_OUT == $past(st_r.shift_r[31]))
        else $error("channel 1 missing on secondary pin");
    disabled_float_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (fall_ev && st_r.hit_r && !st_r.ch1_en_r) |=>
        ($past(st_r.pinsel_r[0]) ? SECONDARY_SERIAL_OUT_OE_B : DOUT_OE_B))
        else $error("disabled channel 1 slot driven");
    slot_match_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (rise_ev && is_tdm && st_r.framed_r && !start_l) ##1 (st_r.hit_r && $stable(st_r.ch1_slot_r)) |->
        st_r.slot_r == {1'b0, st_r.ch1_slot_r} && st_r.delay_r == 6'h00)
        else $error("channel 1 placed in wrong slot");
    reserved_zero_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (REG_ADDR == ats_pkg::ADDR_CH1) |=> REG_RDATA[7:6] == 2'h0)
        else $error("reserved bits read nonzero");
    bad_format_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (rise_ev && st_r.proto_r == ats_pkg::PROTO_RSVD) |=> !st_r.framed_r)
        else $error("reserved format started a frame");
    slot_wrap_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (rise_ev && st_r.framed_r && st_r.delay_r == 6'h00 && st_r.bit_r == 6'(len - 6'h01)) |=> st_r.bit_r == 6'h00)
        else $error("slot length not honoured");
    fill_zero_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (fall_ev && !st_r.hit_r && !st_r.fill_r) |=> !DOUT_OE_B && !DOUT && !SECONDARY_SERIAL_OUT_OE_B &&
        !SECONDARY_SERIAL_OUT)
        else $error("unused cycle not driven low");
    fill_float_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        (fall_ev && !st_r.hit_r && st_r.fill_r) |=> DOUT_OE_B && SECONDARY_SERIAL_OUT_OE_B)
        else $error("unused cycle not released");
endmodule : ats_slot_mapper

// *** tb/ats_host_model.sv ***
// Host audio port model: makes bit clock and frame sync, captures both data pins
`timescale 1ns/1ps
module ats_host_model (
    input wire logic mclk, // Pacing clock
    output logic bclk, // Bit clock, stands still between frames
    output logic fsync, // Frame sync
    input wire logic dout, // Primary data
    input wire logic dout_oe_b, // Primary enable, low drives
    input wire logic sec, // Secondary data
    input wire logic sec_oe_b, // Secondary enable, low drives
    output logic [1:0] bits, // Captured {primary, secondary}, Z when released
    output logic stb // One pulse per captured bit
);
    initial
    begin
        bclk = 1'h0;
        fsync = 1'h0;
        stb = 1'h0;
        bits = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One lead-in edge at the idle sync level, then n edges; sync moves with the
    // falling edge; the low half period is six system clocks and the high half seven, so the slow edge
    // is surely seen and the pins have settled before they are captured
    task automatic frame(input int n, input int h, input logic [1:0] proto);
        logic fs;
        for (int e = -1; e < n; e++)
        begin
            fs = (proto == 2'h0) ? (e == 0) : (proto == 2'h2) ? (e >= 0 && e < h) : (proto == 2'h1) && (e < 0 || e >= h);
            @(negedge mclk);
            bclk = 1'h0;
            fsync = fs;
            repeat (6) @(negedge mclk);
            bclk = 1'h1;
            bits = {dout_oe_b ? 1'hZ : dout, sec_oe_b ? 1'hZ : sec};
            stb = (e > 0);
            @(negedge mclk);
            stb = 1'h0;
            repeat (5) @(negedge mclk);
        end
    endtask : frame
endmodule : ats_host_model

// *** tb/ats_slot_mapper_tb.sv ***
// Self-checking bench of the transmit slot mapper
`timescale 1ns/1ps
module ats_slot_mapper_tb;
    logic MCLK, RST_B, REG_WE, BCLK, FSYNC, S_VALID, S_READY, DOUT, DOUT_OE_B, SSO, SSO_OE_B, stb;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
    logic [31:0] S_DATA, seed;
    logic [1:0] bits;
    logic [1:0] eq[$]; // Expected pin pairs, oldest first
    logic [31:0] wq[$]; // Words accepted by the buffer
    int error_cnt, cmp_count;
    int c[9]; // Current row: proto, len code, offset, pin, enable, slot, fill, edges, half
    int lens[4] = '{16, 20, 24, 32};
    logic [7:0] rst_v[5] = '{8'h30, 8'h00, 8'h00, 8'h00, 8'h20};
    logic [7:0] msk_v[5] = '{8'hF0, 8'h40, 8'h1F, 8'hFF, 8'h3F};
    int tbl[7][9] = '{'{0, 0, 0, 0, 1, 0, 0, 21, 0}, '{0, 0, 3, 1, 1, 2, 1, 54, 0},
        '{2, 2, 1, 0, 1, 16, 0, 59, 30}, '{1, 3, 0, 1, 1, 1, 0, 74, 68},
        '{0, 1, 31, 0, 1, 0, 0, 54, 0}, '{0, 0, 0, 1, 0, 0, 0, 21, 0}, '{3, 0, 0, 0, 1, 0, 0, 10, 0}};

    ats_slot_mapper i_dut (.MCLK(MCLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WE(REG_WE), .REG_RDATA(REG_RDATA), .BCLK(BCLK), .FSYNC(FSYNC), .S_VALID(S_VALID),
        .S_DATA(S_DATA), .S_READY(S_READY), .DOUT(DOUT), .DOUT_OE_B(DOUT_OE_B),
        .SECONDARY_SERIAL_OUT(SSO), .SECONDARY_SERIAL_OUT_OE_B(SSO_OE_B));
    ats_host_model i_host (.mclk(MCLK), .bclk(BCLK), .fsync(FSYNC), .dout(DOUT), .dout_oe_b(DOUT_OE_B),
        .sec(SSO), .sec_oe_b(SSO_OE_B), .bits(bits), .stb(stb));

    initial
    begin
        MCLK = 1'h0;
        forever #25 MCLK = ~MCLK;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic fail(input string m);
        error_cnt++;
        $display("mismatch at %0t: %s", $time, m);
    endtask : fail

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic cmp_flag(input logic g, input logic e, input string m);
        cmp_count++;
        if (g !== e) fail(m);
    endtask : cmp_flag

    task automatic cmp_bit(input logic [1:0] e);
        cmp_count++;
        if (bits !== e) fail($sformatf("pins %b expected %b", bits, e));
    endtask : cmp_bit

    // Read data is registered, so it is looked at one cycle after the address
    task automatic cmp_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge MCLK);
        REG_ADDR = a;
        @(negedge MCLK);
        cmp_count++;
        if (REG_RDATA !== e) fail($sformatf("reg %h read %h expected %h", a, REG_RDATA, e));
    endtask : cmp_reg

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge MCLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WE = 1'h1;
        @(negedge MCLK);
        REG_WE = 1'h0;
    endtask : wr

    // Reserved bits always written as zero; other channels' pin choices random
    task automatic cfg(input int k);
        logic [31:0] r;
        r = rnd();
        c = tbl[k];
        wr(8'h1A, {c[0][1:0], c[1][1:0], 4'h0});
        wr(8'h1B, {1'h0, c[6][0], 6'h00});
        wr(8'h1C, {3'h0, c[2][4:0]});
        wr(8'h1D, {r[7:1], c[3][0]});
        wr(8'h1E, {2'h0, c[4][0], c[5][4:0]});
    endtask : cfg

    ////////////////////////////////////////////////////////////////////////////
    // Note what each captured edge must show, then let the host run the frame
    task automatic run();
        int p, q, s, b;
        logic dv;
        logic [1:0] fl, x;
        logic [31:0] w;
        bit got;
        fl = c[6] ? 2'hZ : 2'h0;
        got = 0;
        w = 32'h0;
        for (int e = 1; e < c[7]; e++)
        begin
            p = (c[0] != 0 && e > c[8]) ? e - c[8] - 1 : e - 1;
            q = p - c[2] - (c[0] == 1);
            s = (c[0] == 3 || q < 0) ? 99 : q / lens[c[1]];
            b = q % lens[c[1]];
            if (s < 99 && c[0] != 0) s = (s > 15) ? 99 : s + ((e > c[8]) ? 16 : 0);
            x = fl;
            if (s == c[5])
            begin
                // An empty buffer sends zeros in channel 1's slot
                if (!got && c[4] != 0) w = (wq.size() > 0) ? wq.pop_front() : 32'h0;
                got = 1;
                dv = c[4] ? w[31 - b] : 1'hZ;
                x = c[3] ? {fl[1], dv} : {dv, fl[0]};
            end
            eq.push_back(x);
        end
        i_host.frame(c[7], c[8], c[0][1:0]);
        if (eq.size() != 0) fail("bits missing");
    endtask : run

    // Watcher: each captured bit is matched against the oldest note
    always @(posedge stb)
    begin
        if (eq.size() == 0) fail("unexpected bit");
        else cmp_bit(eq.pop_front());
    end

    initial
    begin
        repeat (60000) @(posedge MCLK);
        fail("watchdog expired");
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        RST_B = 1'h0;
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WE = 1'h0;
        S_VALID = 1'h0;
        S_DATA = 32'h0;
        error_cnt = 0;
        cmp_count = 0;
        seed = 32'hE92A3E34;
        repeat (2) @(negedge MCLK);
        RST_B = 1'h1;
        for (int i = 0; i < 5; i++) cmp_reg(8'(8'h1A + i), rst_v[i]);
        // Ones in every field bit, the unmapped byte too; the format and fill bytes also get ones in reserved bits
        for (int i = 0; i < 6; i++) wr(8'(8'h1A + i), (i == 2) ? 8'h1F : (i >= 4) ? 8'h3F : 8'hFF);
        for (int i = 0; i < 5; i++) cmp_reg(8'(8'h1A + i), msk_v[i]);
        cmp_reg(8'h1F, 8'h00);
        $display("test registers done");
        // Offer 17 words while the link stands still; only 16 fit
        S_VALID = 1'h1;
        for (int i = 0; i < 17; i++)
        begin
            S_DATA = rnd();
            if (S_READY === 1'h1) wq.push_back(S_DATA);
            @(negedge MCLK);
        end
        S_VALID = 1'h0;
        cmp_flag(S_READY, 1'h0, "ready while full");
        cmp_flag(wq.size() == 16, 1'h1, "buffer depth");
        $display("test fill done");
        // Formats and offsets, then drain to empty, then disabled and reserved format
        for (int t = 0; t < 19; t++)
        begin
            cfg((t < 5) ? t : (t < 17) ? 0 : t - 12);
            run();
            $display("test frame %0d done", t);
        end
        cmp_flag(S_READY, 1'h1, "ready after drain");
        give_verdict();
    end
endmodule : ats_slot_mapper_tb
